// ===== rtl/ipl_pkg.sv
// ipl_pkg: offsets, field positions, reset values and codes of the priority-level registers
// assumes word-addressed peripheral bus with 16-bit data
package ipl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus shape
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets (word index from module base)
	localparam logic [ADDR_W-1:0] IRQ_LEVEL_CFG_0_OFS = 5'h00;
	localparam logic [ADDR_W-1:0] IRQ_LEVEL_CFG_1_OFS = 5'h01;
	localparam logic [ADDR_W-1:0] IRQ_LEVEL_CFG_2_OFS = 5'h02;
	localparam int unsigned       NUM_REGS            = 3;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and writable bits (reserved bits are zero in the mask)
	localparam logic [DATA_W-1:0] IRQ_LEVEL_CFG_0_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] IRQ_LEVEL_CFG_1_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] IRQ_LEVEL_CFG_2_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] IRQ_LEVEL_CFG_0_MASK = 16'hF3FF;
	localparam logic [DATA_W-1:0] IRQ_LEVEL_CFG_1_MASK = 16'hC03F;
	localparam logic [DATA_W-1:0] IRQ_LEVEL_CFG_2_MASK = 16'hC3FF;
	localparam logic [DATA_W-1:0] UNMAPPED_RDATA       = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// field positions (low bit of each two-bit field)
	localparam int unsigned SYNTH_LOCK_LEVEL_LSB      = 14;
	localparam int unsigned LOW_VOLTAGE_LEVEL_LSB     = 12;
	localparam int unsigned DEBUG_RX_FULL_LEVEL_LSB   = 8;
	localparam int unsigned DEBUG_TX_EMPTY_LEVEL_LSB  = 6;
	localparam int unsigned TRACE_BUF_LEVEL_LSB       = 4;
	localparam int unsigned BREAKPOINT_LEVEL_LSB      = 2;
	localparam int unsigned STEP_COUNT_LEVEL_LSB      = 0;
	localparam int unsigned PORT_D_PIN_LEVEL_LSB      = 14;
	localparam int unsigned FLASH_BUF_EMPTY_LEVEL_LSB = 4;
	localparam int unsigned FLASH_DONE_LEVEL_LSB      = 2;
	localparam int unsigned FLASH_FAULT_LEVEL_LSB     = 0;
	localparam int unsigned SERIAL_TX_EMPTY_LEVEL_LSB = 14;
	localparam int unsigned SPI_TX_EMPTY_LEVEL_LSB    = 8;
	localparam int unsigned SPI_RX_FULL_LEVEL_LSB     = 6;
	localparam int unsigned PORT_A_PIN_LEVEL_LSB      = 4;
	localparam int unsigned PORT_B_PIN_LEVEL_LSB      = 2;
	localparam int unsigned PORT_C_PIN_LEVEL_LSB      = 0;

	////////////////////////////////////////////////////////////////////////////////
	// source table: index = arbitration order, 0 wins ties
	localparam int unsigned NUM_SRC = 17;
	localparam int unsigned SRC_W   = 5;

	localparam int unsigned SRC_REG [NUM_SRC] = '{
		0, 0, 0, 0, 0, 0, 0,
		1, 1, 1, 1,
		2, 2, 2, 2, 2, 2
	};
	localparam int unsigned SRC_LSB [NUM_SRC] = '{
		SYNTH_LOCK_LEVEL_LSB, LOW_VOLTAGE_LEVEL_LSB, DEBUG_RX_FULL_LEVEL_LSB,
		DEBUG_TX_EMPTY_LEVEL_LSB, TRACE_BUF_LEVEL_LSB, BREAKPOINT_LEVEL_LSB,
		STEP_COUNT_LEVEL_LSB,
		PORT_D_PIN_LEVEL_LSB, FLASH_BUF_EMPTY_LEVEL_LSB, FLASH_DONE_LEVEL_LSB,
		FLASH_FAULT_LEVEL_LSB,
		SERIAL_TX_EMPTY_LEVEL_LSB, SPI_TX_EMPTY_LEVEL_LSB, SPI_RX_FULL_LEVEL_LSB,
		PORT_A_PIN_LEVEL_LSB, PORT_B_PIN_LEVEL_LSB, PORT_C_PIN_LEVEL_LSB
	};

	////////////////////////////////////////////////////////////////////////////////
	// level classes and codes
	typedef enum logic [0:0] {
		IPL_CLASS_NORMAL = 1'b0,
		IPL_CLASS_HIGH   = 1'b1
	} ipl_class_t;

	localparam ipl_class_t SRC_CLASS [NUM_SRC] = '{
		IPL_CLASS_HIGH, IPL_CLASS_HIGH, IPL_CLASS_HIGH, IPL_CLASS_HIGH,
		IPL_CLASS_HIGH, IPL_CLASS_HIGH, IPL_CLASS_HIGH,
		IPL_CLASS_NORMAL, IPL_CLASS_NORMAL, IPL_CLASS_NORMAL, IPL_CLASS_NORMAL,
		IPL_CLASS_NORMAL, IPL_CLASS_NORMAL, IPL_CLASS_NORMAL, IPL_CLASS_NORMAL,
		IPL_CLASS_NORMAL, IPL_CLASS_NORMAL
	};

	localparam logic [1:0] FIELD_DISABLED = 2'h0;
	localparam logic [1:0] NORMAL_OFFSET  = 2'h1;

endpackage : ipl_pkg

// ===== rtl/ipl_dec_if.sv
// ipl_dec_if: one level field on its way through a decoder
// assumes ipl_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none

interface ipl_dec_if;
	logic               [1:0] field;
	ipl_pkg::ipl_class_t      cls;
	logic                     enable;
	logic               [1:0] level;

	modport dec (
		input  field,
		input  cls,
		output enable,
		output level
	);
	modport user (
		output field,
		output cls,
		input  enable,
		input  level
	);
endinterface : ipl_dec_if

`default_nettype wire

// ===== rtl/ipl_level_dec.sv
// ipl_level_dec: turns a two-bit level field into enable and priority
// assumes the class of the field is a constant from the source table
`timescale 1ns/1ps
`default_nettype none

module ipl_level_dec (
	ipl_dec_if.dec port
);

	////////////////////////////////////////////////////////////////////////////////
	// 00 disables; otherwise high class maps 1..3, normal maps 0..2
	always_comb begin
		port.enable = (port.field != ipl_pkg::FIELD_DISABLED);
		if (port.cls == ipl_pkg::IPL_CLASS_HIGH) begin
			port.level = port.field;
		end else begin
			port.level = 2'(port.field - ipl_pkg::NORMAL_OFFSET);
		end
	end

endmodule : ipl_level_dec

`default_nettype wire

// ===== rtl/ipl_regs.sv
// ipl_regs: three priority-level registers and the arbiter they feed
// assumes a word-addressed peripheral bus, one-cycle strobes, synchronous inputs
`timescale 1ns/1ps
`default_nettype none

module ipl_regs (
	input  wire logic                                    clk_in,
	input  wire logic                                    sys_rst_in,
	input  wire logic [ipl_pkg::ADDR_W-1:0]              bus_addr_in,
	input  wire logic                                    bus_wr_in,
	input  wire logic                                    bus_rd_in,
	input  wire logic [ipl_pkg::DATA_W-1:0]              bus_wdata_in,
	output logic      [ipl_pkg::DATA_W-1:0]              bus_rdata_out,
	input  wire logic [ipl_pkg::NUM_SRC-1:0]             irq_req_in,
	output logic      [ipl_pkg::NUM_SRC-1:0]             src_enable_out,
	output logic      [2*ipl_pkg::NUM_SRC-1:0]           src_level_out,
	output logic      [3:0]                              level_pending_out,
	output logic                                         irq_active_out,
	output logic      [1:0]                              irq_level_out,
	output logic      [ipl_pkg::SRC_W-1:0]               irq_source_out,
	output logic      [1:0]                              synth_lock_level_out,
	output logic      [1:0]                              low_voltage_level_out,
	output logic      [1:0]                              debug_rx_full_level_out,
	output logic      [1:0]                              debug_tx_empty_level_out,
	output logic      [1:0]                              trace_buf_level_out,
	output logic      [1:0]                              breakpoint_level_out,
	output logic      [1:0]                              step_count_level_out,
	output logic      [1:0]                              port_d_pin_level_out,
	output logic      [1:0]                              flash_buf_empty_level_out,
	output logic      [1:0]                              flash_done_level_out,
	output logic      [1:0]                              flash_fault_level_out,
	output logic      [1:0]                              serial_tx_empty_level_out,
	output logic      [1:0]                              spi_tx_empty_level_out,
	output logic      [1:0]                              spi_rx_full_level_out,
	output logic      [1:0]                              port_a_pin_level_out,
	output logic      [1:0]                              port_b_pin_level_out,
	output logic      [1:0]                              port_c_pin_level_out
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [ipl_pkg::DATA_W-1:0] cfg0;
		logic [ipl_pkg::DATA_W-1:0] cfg1;
		logic [ipl_pkg::DATA_W-1:0] cfg2;
		logic [ipl_pkg::DATA_W-1:0] rdata;
		logic                       act;
		logic [1:0]                 lvl;
		logic [ipl_pkg::SRC_W-1:0]  src;
		logic [3:0]                 pend;
	} ipl_state_t;

	ipl_state_t state_ff;
	ipl_state_t nxt_state;

	////////////////////////////////////////////////////////////////////////////////
	// field decode, one decoder per source

	logic [ipl_pkg::NUM_SRC-1:0]   dec_en;
	logic [2*ipl_pkg::NUM_SRC-1:0] dec_lvl;
	logic [2*ipl_pkg::NUM_SRC-1:0] raw_field;

	generate
		for (genvar s = 0; s < ipl_pkg::NUM_SRC; s++) begin : g_src
			ipl_dec_if dec_port ();

			always_comb begin
				unique case (ipl_pkg::SRC_REG[s])
					0: begin
						raw_field[2*s +: 2] = state_ff.cfg0[ipl_pkg::SRC_LSB[s] +: 2];
					end
					1: begin
						raw_field[2*s +: 2] = state_ff.cfg1[ipl_pkg::SRC_LSB[s] +: 2];
					end
					default: begin
						raw_field[2*s +: 2] = state_ff.cfg2[ipl_pkg::SRC_LSB[s] +: 2];
					end
				endcase
			end

			assign dec_port.field    = raw_field[2*s +: 2];
			assign dec_port.cls      = ipl_pkg::SRC_CLASS[s];
			assign dec_en[s]         = dec_port.enable;
			assign dec_lvl[2*s +: 2] = dec_port.level;

			ipl_level_dec u_dec (
				.port (dec_port.dec)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// next state: bus access and arbitration

	always_comb begin
		logic                      found;
		logic [1:0]                best_lvl;
		logic [ipl_pkg::SRC_W-1:0] best_src;
		logic [3:0]                pend;
		found     = 1'b0;
		best_lvl  = 2'h0;
		best_src  = '0;
		pend      = 4'h0;
		nxt_state = state_ff;

		// writes land only on level fields; reserved bits stay zero
		if (bus_wr_in) begin
			unique case (bus_addr_in)
				ipl_pkg::IRQ_LEVEL_CFG_0_OFS: begin
					nxt_state.cfg0 = bus_wdata_in & ipl_pkg::IRQ_LEVEL_CFG_0_MASK;
				end
				ipl_pkg::IRQ_LEVEL_CFG_1_OFS: begin
					nxt_state.cfg1 = bus_wdata_in & ipl_pkg::IRQ_LEVEL_CFG_1_MASK;
				end
				ipl_pkg::IRQ_LEVEL_CFG_2_OFS: begin
					nxt_state.cfg2 = bus_wdata_in & ipl_pkg::IRQ_LEVEL_CFG_2_MASK;
				end
				default: begin
					nxt_state.cfg0 = state_ff.cfg0;
				end
			endcase
		end

		// read data is captured on the read strobe and held until the next read
		if (bus_rd_in) begin
			unique case (bus_addr_in)
				ipl_pkg::IRQ_LEVEL_CFG_0_OFS: begin
					nxt_state.rdata = state_ff.cfg0;
				end
				ipl_pkg::IRQ_LEVEL_CFG_1_OFS: begin
					nxt_state.rdata = state_ff.cfg1;
				end
				ipl_pkg::IRQ_LEVEL_CFG_2_OFS: begin
					nxt_state.rdata = state_ff.cfg2;
				end
				default: begin
					nxt_state.rdata = ipl_pkg::UNMAPPED_RDATA;
				end
			endcase
		end

		// highest level wins; strict compare keeps the lowest index on a tie
		for (int s = 0; s < ipl_pkg::NUM_SRC; s++) begin
			if (irq_req_in[s] && dec_en[s]) begin
				pend[dec_lvl[2*s +: 2]] = 1'b1;
				if (!found || (dec_lvl[2*s +: 2] > best_lvl)) begin
					found    = 1'b1;
					best_lvl = dec_lvl[2*s +: 2];
					best_src = ipl_pkg::SRC_W'(s);
				end
			end
		end

		nxt_state.act  = found;
		nxt_state.lvl  = best_lvl;
		nxt_state.src  = best_src;
		nxt_state.pend = pend;
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_ff.cfg0  <= ipl_pkg::IRQ_LEVEL_CFG_0_RST;
			state_ff.cfg1  <= ipl_pkg::IRQ_LEVEL_CFG_1_RST;
			state_ff.cfg2  <= ipl_pkg::IRQ_LEVEL_CFG_2_RST;
			state_ff.rdata <= ipl_pkg::UNMAPPED_RDATA;
			state_ff.act   <= 1'b0;
			state_ff.lvl   <= 2'h0;
			state_ff.src   <= '0;
			state_ff.pend  <= 4'h0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign bus_rdata_out     = state_ff.rdata;
	assign src_enable_out    = dec_en;
	assign src_level_out     = dec_lvl;
	assign level_pending_out = state_ff.pend;
	assign irq_active_out    = state_ff.act;
	assign irq_level_out     = state_ff.lvl;
	assign irq_source_out    = state_ff.src;

	assign synth_lock_level_out      = state_ff.cfg0[ipl_pkg::SYNTH_LOCK_LEVEL_LSB +: 2];
	assign low_voltage_level_out     = state_ff.cfg0[ipl_pkg::LOW_VOLTAGE_LEVEL_LSB +: 2];
	assign debug_rx_full_level_out   = state_ff.cfg0[ipl_pkg::DEBUG_RX_FULL_LEVEL_LSB +: 2];
	assign debug_tx_empty_level_out  = state_ff.cfg0[ipl_pkg::DEBUG_TX_EMPTY_LEVEL_LSB +: 2];
	assign trace_buf_level_out       = state_ff.cfg0[ipl_pkg::TRACE_BUF_LEVEL_LSB +: 2];
	assign breakpoint_level_out      = state_ff.cfg0[ipl_pkg::BREAKPOINT_LEVEL_LSB +: 2];
	assign step_count_level_out      = state_ff.cfg0[ipl_pkg::STEP_COUNT_LEVEL_LSB +: 2];
	assign port_d_pin_level_out      = state_ff.cfg1[ipl_pkg::PORT_D_PIN_LEVEL_LSB +: 2];
	assign flash_buf_empty_level_out = state_ff.cfg1[ipl_pkg::FLASH_BUF_EMPTY_LEVEL_LSB +: 2];
	assign flash_done_level_out      = state_ff.cfg1[ipl_pkg::FLASH_DONE_LEVEL_LSB +: 2];
	assign flash_fault_level_out     = state_ff.cfg1[ipl_pkg::FLASH_FAULT_LEVEL_LSB +: 2];
	assign serial_tx_empty_level_out = state_ff.cfg2[ipl_pkg::SERIAL_TX_EMPTY_LEVEL_LSB +: 2];
	assign spi_tx_empty_level_out    = state_ff.cfg2[ipl_pkg::SPI_TX_EMPTY_LEVEL_LSB +: 2];
	assign spi_rx_full_level_out     = state_ff.cfg2[ipl_pkg::SPI_RX_FULL_LEVEL_LSB +: 2];
	assign port_a_pin_level_out      = state_ff.cfg2[ipl_pkg::PORT_A_PIN_LEVEL_LSB +: 2];
	assign port_b_pin_level_out      = state_ff.cfg2[ipl_pkg::PORT_B_PIN_LEVEL_LSB +: 2];
	assign port_c_pin_level_out      = state_ff.cfg2[ipl_pkg::PORT_C_PIN_LEVEL_LSB +: 2];

endmodule : ipl_regs

`default_nettype wire

// ===== verification/ipl_regs_properties.sv
// ipl_regs_properties: timing checks on the priority-level registers
// assumes bound to ipl_regs, single clock domain
`timescale 1ns/1ps
`default_nettype none
module ipl_regs_chk (
	input wire logic                         clk_in,
	input wire logic                         sys_rst_in,
	input wire logic [ipl_pkg::ADDR_W-1:0]   bus_addr_in,
	input wire logic                         bus_wr_in,
	input wire logic                         bus_rd_in,
	input wire logic [ipl_pkg::DATA_W-1:0]   bus_wdata_in,
	input wire logic [ipl_pkg::DATA_W-1:0]   bus_rdata_out,
	input wire logic [ipl_pkg::NUM_SRC-1:0]  irq_req_in,
	input wire logic [ipl_pkg::NUM_SRC-1:0]  src_enable_out,
	input wire logic [2*ipl_pkg::NUM_SRC-1:0] src_level_out,
	input wire logic                         irq_active_out,
	input wire logic [1:0]                   synth_lock_level_out,
	input wire logic [1:0]                   step_count_level_out,
	input wire logic [1:0]                   flash_fault_level_out,
	input wire logic [1:0]                   port_c_pin_level_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////////////
	a_wr_lock_field: assert property (bus_wr_in && bus_addr_in == 5'h00
		|=> synth_lock_level_out == $past(bus_wdata_in[15:14])) else $error("lock field lost");
	a_wr_fault_field: assert property (bus_wr_in && bus_addr_in == 5'h01
		|=> flash_fault_level_out == $past(bus_wdata_in[1:0])) else $error("fault field lost");
	a_wr_port_c: assert property (bus_wr_in && bus_addr_in == 5'h02
		|=> port_c_pin_level_out == $past(bus_wdata_in[1:0])) else $error("port c field lost");
	a_field_holds: assert property (!bus_wr_in |=> $stable(step_count_level_out))
		else $error("field changed without write");
	a_rsv_read_zero: assert property (bus_rd_in && bus_addr_in == 5'h00
		|=> bus_rdata_out[11:10] == 2'h0) else $error("reserved bits read set");
	a_unmapped_zero: assert property (bus_rd_in && bus_addr_in > 5'h02
		|=> bus_rdata_out == 16'h0000) else $error("unmapped read not zero");
	a_rdata_stands: assert property (!bus_rd_in |=> $stable(bus_rdata_out))
		else $error("read data moved");
	a_high_decode: assert property (src_enable_out[6] |->
		src_level_out[13:12] == step_count_level_out) else $error("high level wrong");
	a_high_enable: assert property ((step_count_level_out != 2'h0) == src_enable_out[6])
		else $error("high enable wrong");
	a_normal_decode: assert property (src_enable_out[16] |->
		src_level_out[33:32] == port_c_pin_level_out - 2'h1) else $error("normal level wrong");
	a_idle_arbiter: assert property (irq_req_in == 17'h00000 |=> !irq_active_out)
		else $error("active with no request");
	a_reset_off: assert property ($fell(sys_rst_in) |-> synth_lock_level_out == 2'h0
		&& port_c_pin_level_out == 2'h0) else $error("field not cleared by reset");
endmodule : ipl_regs_chk
bind ipl_regs ipl_regs_chk i_chk (.*);
`default_nettype wire

// ===== verification/ipl_req_model.sv
// ipl_req_model: interrupt sources raising request levels
// assumes the bench sets the wanted pattern between falling edges
`timescale 1ns/1ps
`default_nettype none
module ipl_req_model (
	input  wire logic        clk_in,
	input  wire logic [16:0] want_in,
	output logic      [16:0] irq_req_out
);
	always @(negedge clk_in) begin
		irq_req_out <= want_in;
	end
endmodule : ipl_req_model
`default_nettype wire

// ===== verification/ipl_regs_bench.sv
// ipl_regs_bench: self-checking bench of the priority-level registers
// assumes ipl_pkg, design and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module ipl_regs_bench;
	logic        clk_in, sys_rst_in, bus_wr_in, bus_rd_in, irq_active_out;
	logic [4:0]  bus_addr_in, irq_source_out;
	logic [15:0] bus_wdata_in, bus_rdata_out, rd_val;
	logic [16:0] irq_req_in, src_enable_out, want;
	logic [33:0] src_level_out;
	logic [3:0]  level_pending_out;
	logic [1:0]  irq_level_out, synth_lock_level_out, low_voltage_level_out;
	logic [1:0]  debug_rx_full_level_out, debug_tx_empty_level_out, trace_buf_level_out;
	logic [1:0]  breakpoint_level_out, step_count_level_out, port_d_pin_level_out;
	logic [1:0]  flash_buf_empty_level_out, flash_done_level_out, flash_fault_level_out;
	logic [1:0]  serial_tx_empty_level_out, spi_tx_empty_level_out, spi_rx_full_level_out;
	logic [1:0]  port_a_pin_level_out, port_b_pin_level_out, port_c_pin_level_out;
	int          n_mismatch = 0;
	int          total_checks = 0;
	ipl_regs i_dut (.*);
	ipl_req_model i_src (.clk_in(clk_in), .want_in(want), .irq_req_out(irq_req_in));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_in);
		bus_addr_in = a;
		bus_wdata_in = d;
		bus_wr_in = 1'b1;
		@(negedge clk_in);
		bus_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		@(negedge clk_in);
		bus_addr_in = a;
		bus_rd_in = 1'b1;
		@(negedge clk_in);
		bus_rd_in = 1'b0;
		rd_val = bus_rdata_out;
	endtask : rd
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 3; i++) begin
			rd(i[4:0]);
			chk(rd_val, 16'h0000);
		end
		chk(src_enable_out, 17'h00000);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_masks();
		logic [15:0] m [3] = '{16'hF3FF, 16'hC03F, 16'hC3FF};
		for (int i = 0; i < 3; i++) begin
			wr(i[4:0], 16'hFFFF);
			rd(i[4:0]);
			chk(rd_val, m[i]);
		end
		wr(5'h03, 16'hFFFF);
		rd(5'h03);
		chk(rd_val, 16'h0000);
		rd(5'h00);
		chk(rd_val, 16'hF3FF);
		$display("t_masks done");
	endtask : t_masks
	task automatic t_fields();
		wr(5'h00, 16'hB1B4);
		wr(5'h01, 16'h8039);
		wr(5'h02, 16'h4264);
		chk({synth_lock_level_out, low_voltage_level_out, 2'h0, debug_rx_full_level_out,
			debug_tx_empty_level_out, trace_buf_level_out, breakpoint_level_out,
			step_count_level_out}, 16'hB1B4);
		chk({port_d_pin_level_out, 8'h00, flash_buf_empty_level_out, flash_done_level_out,
			flash_fault_level_out}, 16'h8039);
		chk({serial_tx_empty_level_out, 4'h0, spi_tx_empty_level_out, spi_rx_full_level_out,
			port_a_pin_level_out, port_b_pin_level_out, port_c_pin_level_out},
			16'h4264);
		$display("t_fields done");
	endtask : t_fields
	task automatic t_decode();
		for (int c = 0; c < 4; c++) begin
			wr(5'h00, {14'h0000, c[1:0]});
			wr(5'h02, {14'h0000, c[1:0]});
			chk({src_enable_out[6], src_level_out[13:12]}, {c != 0, c[1:0]});
			chk(src_enable_out[16], c != 0);
			if (c != 0) chk(src_level_out[33:32], c[1:0] - 2'h1);
		end
		$display("t_decode done");
	endtask : t_decode
	task automatic t_arb();
		wr(5'h00, 16'h0000);
		wr(5'h02, 16'h003D);
		want = 17'h1C000;
		repeat (3) @(negedge clk_in);
		chk({irq_active_out, irq_level_out, irq_source_out, level_pending_out},
			{1'b1, 2'h2, 5'h0E, 4'h5});
		want = 17'h18000;
		repeat (3) @(negedge clk_in);
		chk({irq_source_out, level_pending_out}, {5'h0F, 4'h5});
		want = 17'h18080;
		repeat (3) @(negedge clk_in);
		chk({irq_level_out, irq_source_out, level_pending_out}, {2'h2, 5'h0F, 4'h7});
		want = 17'h00000;
		repeat (3) @(negedge clk_in);
		chk(irq_active_out, 1'b0);
		$display("t_arb done");
	endtask : t_arb
	task automatic t_rerst();
		wr(5'h00, 16'hF3FF);
		@(negedge clk_in);
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		sys_rst_in = 1'b0;
		chk({synth_lock_level_out, step_count_level_out}, 4'h0);
		rd(5'h00);
		chk(rd_val, 16'h0000);
		$display("t_rerst done");
	endtask : t_rerst
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst_in = 1'b1;
		bus_wr_in = 1'b0;
		bus_rd_in = 1'b0;
		bus_addr_in = 5'h00;
		bus_wdata_in = 16'h0000;
		want = 17'h00000;
		repeat (2) @(negedge clk_in);
		sys_rst_in = 1'b0;
		t_reset();
		t_masks();
		t_fields();
		t_decode();
		t_arb();
		t_rerst();
		tally_and_finish();
	end
	initial begin
		#100us;
		n_mismatch++;
		tally_and_finish();
	end
endmodule : ipl_regs_bench
`default_nettype wire
